/* reset_and_watchdog_control.sv */
// reset source combiner, startup delay, cause flags and watchdog
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - reset reloads registers, core restarts at vector
// - port reset follows any source without clock
// - delay counter stretches reset after sources release
// - five reset sources are combined
// - testport register one holds reset
// - poweron release starts delay, drop reasserts
// - long pin low resets, delay after release
// - enabled brownout resets at once, delays after
// - watchdog reset pulse lasts one clock
// - watchdog counts on its own 1 MHz tick
// - restart, disable or chip reset clear watchdog
// - eight timeouts; expiry resets the device
// - disable needs protected turnoff sequence
// - bandgap on for brownout, comparator or converter
// - bit 4 flags testport reset
// - bit 3 flags watchdog reset
// - bit 2 flags brownout reset
// - bit 1 flags pin reset
// - bit 0 flags poweron, cleared only by software
// - watchdog control bits 7:5 read zero
// - turnoff enable self-clears after four cycles
// - enable clears only within turnoff window or on internal reset
// - prescale selects 16384 doubling to 2097152 cycles
module reset_and_watchdog_control
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic poweron_detect,
   input wire logic reset_pin_n,
   input wire logic brownout_detector,
   input wire logic brownout_enable_fuse,
   input wire logic testport_reset_instruction,
   input wire logic [3:0] clock_select_fuse,
   input wire logic comparator_bandgap_select,
   input wire logic converter_enable,
   output logic port_reset,
   output logic internal_reset,
   output logic bandgap_enable
);
   import rst_wdt_pkg::*;

   typedef struct packed {
      logic aw_held;
      logic [3:0] aw_addr;
      logic w_held;
      logic [7:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic [4:0] flags;
      logic wd_enable;
      logic turnoff;
      logic [2:0] turnoff_count;
      logic [2:0] prescale;
      logic [6:0] osc_div;
      logic osc_tick;
      logic [watchdog_counter_width-1:0] wd_count;
      logic wd_pulse;
      logic [4:0] src_sync1;
      logic [4:0] src_sync2;
      logic [4:0] src_seen;
      logic [delay_counter_width-1:0] delay_count;
      logic stretched;
   } state_t;

   state_t cur, nxt;

   // fuse value maps to a startup length, doubling per code
   function automatic logic [delay_counter_width-1:0] delay_length(
      input logic [3:0] sel);
      delay_length = delay_counter_width'(delay_base_cycles) << sel;
   endfunction

   // timeout in oscillator cycles, minus one
   function automatic logic [watchdog_counter_width-1:0] wd_limit(
      input logic [2:0] sel);
      logic [watchdog_counter_width-1:0] one;
      one = watchdog_counter_width'(1);
      wd_limit = (one << (watchdog_base_log2 + int'(sel))) - one;
   endfunction

   logic any_source;
   logic [4:0] sources;
   logic aw_go, w_go, ar_go, wr_fire;

   // five sources: testport, watchdog, brownout, pin, poweron
   always_comb begin
      sources[testport_flag_bit] = testport_reset_instruction;
      sources[watchdog_flag_bit] = cur.wd_pulse;
      sources[brownout_flag_bit] = brownout_enable_fuse &
         brownout_detector;
      sources[pin_flag_bit] = ~reset_pin_n;
      sources[poweron_flag_bit] = ~poweron_detect;
      any_source = |sources;
   end

   // port reset asserts from the sources with no clock edge, then holds on the registered stretch
   assign port_reset = any_source | cur.stretched;
   // core and registers held while stretched reset stands
   assign internal_reset = any_source | cur.stretched;
   assign bandgap_enable = brownout_enable_fuse |
      comparator_bandgap_select | converter_enable;

   assign awready = ~cur.aw_held & ~cur.bvalid;
   assign wready = ~cur.w_held & ~cur.bvalid;
   assign arready = ~cur.rvalid;
   assign bvalid = cur.bvalid;
   assign bresp = cur.bresp;
   assign rvalid = cur.rvalid;
   assign rresp = cur.rresp;
   assign rdata = {24'h000000, cur.rdata};
   assign aw_go = awvalid & awready;
   assign w_go = wvalid & wready;
   assign ar_go = arvalid & arready;

   always_comb begin
      logic [3:0] wa;
      logic [7:0] wd;
      logic wl;
      logic wr_ctrl, wr_cause, wr_restart;
      logic [4:0] rose;
      rose = cur.src_sync2 & ~cur.src_seen;
      wa = aw_go ? awaddr : cur.aw_addr;
      wd = w_go ? wdata[7:0] : cur.w_data;
      wl = w_go ? wstrb[0] : cur.w_lane0;
      nxt = cur;
      wr_fire = (cur.aw_held | aw_go) & (cur.w_held | w_go);
      wr_ctrl = wr_fire & wl & (wa == watchdog_control_offset);
      wr_cause = wr_fire & wl & (wa == reset_cause_status_offset);
      wr_restart = wr_fire & wl & (wa == reset_control_offset) &
         wd[restart_bit];

      // bus write path
      if (aw_go) begin
         nxt.aw_held = 1'b1;
         nxt.aw_addr = awaddr;
      end
      if (w_go) begin
         nxt.w_held = 1'b1;
         nxt.w_data = wdata[7:0];
         nxt.w_lane0 = wstrb[0];
      end
      if (wr_fire) begin
         nxt.aw_held = 1'b0;
         nxt.w_held = 1'b0;
         nxt.bvalid = 1'b1;
         nxt.bresp = (wa == reset_cause_status_offset ||
            wa == watchdog_control_offset ||
            wa == reset_control_offset) ? resp_okay : resp_slverr;
      end else if (cur.bvalid & bready) begin
         nxt.bvalid = 1'b0;
      end

      // bus read path
      if (ar_go) begin
         nxt.rvalid = 1'b1;
         nxt.rresp = resp_okay;
         unique case (araddr)
            reset_cause_status_offset: nxt.rdata = {3'h0, cur.flags};
            watchdog_control_offset: begin
               nxt.rdata = {3'h0, cur.turnoff, cur.wd_enable,
                  cur.prescale};
            end
            reset_control_offset: nxt.rdata = 8'h00;
            default: begin
               nxt.rdata = 8'h00;
               nxt.rresp = resp_slverr;
            end
         endcase
      end else if (cur.rvalid & rready) begin
         nxt.rvalid = 1'b0;
      end

      // turnoff window counts down and self clears
      if (cur.turnoff_count != 3'h0) begin
         nxt.turnoff_count = cur.turnoff_count - 3'h1;
         if (cur.turnoff_count == 3'h1) nxt.turnoff = 1'b0;
      end
      if (wr_ctrl) begin
         nxt.prescale = wd[prescale_lsb +: 3];
         if (wd[watchdog_enable_bit]) begin
            nxt.wd_enable = 1'b1;
         end else if (cur.turnoff) begin
            nxt.wd_enable = 1'b0;
         end
         // arming needs enable and turnoff written together
         if (wd[turnoff_enable_bit] & wd[watchdog_enable_bit]) begin
            nxt.turnoff = 1'b1;
            nxt.turnoff_count = turnoff_window_cycles;
         end
      end

      // tick at 1 MHz from system clock divider
      nxt.osc_tick = 1'b0;
      if (cur.osc_div == 7'h00) begin
         nxt.osc_div = 7'(2 * watchdog_osc_divide - 7'h1);
         nxt.osc_tick = 1'b1;
      end else begin
         nxt.osc_div = cur.osc_div - 7'h1;
      end

      nxt.wd_pulse = 1'b0;
      if (!cur.wd_enable || wr_restart) begin
         nxt.wd_count = '0;
      end else if (cur.osc_tick) begin
         if (cur.wd_count >= wd_limit(cur.prescale)) begin
            nxt.wd_count = '0;
            nxt.wd_pulse = 1'b1;
         end else begin
            nxt.wd_count = cur.wd_count + 1'b1;
         end
      end

      // two stage sync then rising edge capture
      nxt.src_sync1 = sources;
      nxt.src_sync2 = cur.src_sync1;
      nxt.src_seen = cur.src_sync2;
      if (wr_cause) nxt.flags = cur.flags & wd[4:0];
      nxt.flags = nxt.flags | rose;
      if (rose[poweron_flag_bit]) begin
         nxt.flags[4:1] = 4'h0;
      end

      // delay counter starts when last source falls
      if (any_source) begin
         nxt.stretched = 1'b1;
         nxt.delay_count = delay_length(clock_select_fuse);
      end else if (cur.delay_count != '0) begin
         nxt.delay_count = cur.delay_count - 1'b1;
      end else begin
         nxt.stretched = 1'b0;
      end

      if (internal_reset) begin
         nxt.wd_enable = 1'b0;
         nxt.turnoff = 1'b0;
         nxt.turnoff_count = 3'h0;
         nxt.prescale = 3'h0;
         nxt.wd_count = '0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cur <= '0;
         cur.flags <= 5'(reset_cause_status_reset);
         cur.stretched <= 1'b1;
         cur.delay_count <= delay_counter_width'(delay_base_cycles);
      end else begin
         cur <= nxt;
      end
   end

   property p_pulse_one;
      @(posedge aclk) disable iff (!aresetn)
      cur.wd_pulse |=> !cur.wd_pulse;
   endproperty
   a_pulse_one: assert property (p_pulse_one)
      else $error("watchdog pulse longer than one cycle");

   property p_turnoff_clear;
      @(posedge aclk) disable iff (!aresetn)
      $rose(cur.turnoff) |-> ##4 !cur.turnoff;
   endproperty
   a_turnoff_clear: assert property (p_turnoff_clear)
      else $error("turnoff enable did not clear after four cycles");

   property p_no_plain_disable;
      @(posedge aclk) disable iff (!aresetn)
      (cur.wd_enable && !cur.turnoff && !internal_reset)
         |=> cur.wd_enable;
   endproperty
   a_no_plain_disable: assert property (p_no_plain_disable)
      else $error("watchdog disabled without turnoff sequence");

   property p_source_resets;
      @(posedge aclk) disable iff (!aresetn)
      any_source |-> port_reset && internal_reset;
   endproperty
   a_source_resets: assert property (p_source_resets)
      else $error("reset source did not reset ports");

   property p_stretch;
      @(posedge aclk) disable iff (!aresetn)
      $fell(any_source) |-> internal_reset [*8];
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("internal reset not stretched");

   property p_bandgap;
      @(posedge aclk) disable iff (!aresetn)
      bandgap_enable == (brownout_enable_fuse ||
         comparator_bandgap_select || converter_enable);
   endproperty
   a_bandgap: assert property (p_bandgap)
      else $error("bandgap enable wrong");

   property p_wd_flag;
      @(posedge aclk) disable iff (!aresetn)
      cur.wd_pulse |-> ##3 cur.flags[watchdog_flag_bit];
   endproperty
   a_wd_flag: assert property (p_wd_flag)
      else $error("watchdog flag not set");

   property p_por_sticky;
      @(posedge aclk) disable iff (!aresetn)
      (cur.flags[poweron_flag_bit] && !(wr_fire && awaddr ==
         reset_cause_status_offset) && !cur.aw_held && !cur.w_held)
         |=> cur.flags[poweron_flag_bit];
   endproperty
   a_por_sticky: assert property (p_por_sticky)
      else $error("poweron flag lost without software write");

   property p_wd_cleared;
      @(posedge aclk) disable iff (!aresetn)
      !cur.wd_enable |=> cur.wd_count == '0;
   endproperty
   a_wd_cleared: assert property (p_wd_cleared)
      else $error("watchdog count not cleared while disabled");

   property p_turnoff_hold;
      @(posedge aclk) disable iff (!aresetn || internal_reset)
      $rose(cur.turnoff) |-> cur.turnoff [*4];
   endproperty
   a_turnoff_hold: assert property (p_turnoff_hold)
      else $error("turnoff enable cleared before four cycles");

   property p_pin_flag;
      @(posedge aclk) disable iff (!aresetn)
      (cur.src_sync2[pin_flag_bit] && !cur.src_seen[pin_flag_bit] &&
         !cur.src_sync2[poweron_flag_bit]) |=> cur.flags[pin_flag_bit];
   endproperty
   a_pin_flag: assert property (p_pin_flag)
      else $error("pin reset flag not captured");

   property p_delay_load;
      @(posedge aclk) disable iff (!aresetn)
      $fell(any_source) |->
         cur.delay_count == delay_length(clock_select_fuse);
   endproperty
   a_delay_load: assert property (p_delay_load)
      else $error("startup delay not loaded from fuse");

   property p_wd_idle;
      @(posedge aclk) disable iff (!aresetn)
      !cur.wd_enable |=> !cur.wd_pulse;
   endproperty
   a_wd_idle: assert property (p_wd_idle)
      else $error("watchdog reset while disabled");
endmodule

`default_nettype wire

/* reset_and_watchdog_control_tb_top.sv */
// self-checking bench for the reset and watchdog controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      failures++; \
      $display("ERROR t=%0t got %0h exp %0h", $time, got, exp); \
   end \
end
module reset_and_watchdog_control_tb_top;
   import rst_wdt_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [3:0] awaddr, araddr, wstrb, clock_select_fuse;
   logic [31:0] wdata, rdata, rd, d;
   logic [1:0] bresp, rresp, resp;
   logic poweron_detect, reset_pin_n, brownout_detector;
   logic brownout_enable_fuse, testport_reset_instruction;
   logic comparator_bandgap_select, converter_enable;
   logic port_reset, internal_reset, bandgap_enable;
   int failures, comparisons, flags, cnt, len;
   int bits[3] = '{pin_flag_bit, brownout_flag_bit, testport_flag_bit};

   reset_and_watchdog_control i_dut (.aclk, .aresetn, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .poweron_detect, .reset_pin_n, .brownout_detector,
      .brownout_enable_fuse, .testport_reset_instruction,
      .clock_select_fuse, .comparator_bandgap_select, .converter_enable,
      .port_reset, .internal_reset, .bandgap_enable);

   task automatic end_sim();
      if (failures == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic guard(input int n);
      if (n > 2000) begin
         failures++;
         end_sim();
      end
   endtask

   // ready lines stay high, so a response is taken at the edge it shows
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] v,
         input logic [3:0] s);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         guard(n);
      end while (bvalid !== 1'b1);
      resp = bresp;
   endtask

   task automatic axi_rd(input logic [3:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         guard(n);
      end while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
   endtask

   task automatic chk_rd(input logic [3:0] a, input int e);
      axi_rd(a);
      `CHK(rd, e)
      `CHK(resp, resp_okay)
   endtask

   // k: 0 pin, 1 brownout, 2 testport, else supply drop; c = stretch
   task automatic pulse(input int k, output int c);
      c = 0;
      case (k)
         0: reset_pin_n <= 1'b0;
         1: brownout_detector <= 1'b1;
         2: testport_reset_instruction <= 1'b1;
         default: poweron_detect <= 1'b0;
      endcase
      #1;
      `CHK(port_reset, 1'b1)
      @(posedge aclk);
      repeat (8) @(posedge aclk);
      `CHK(internal_reset, 1'b1)
      reset_pin_n <= 1'b1;
      brownout_detector <= 1'b0;
      testport_reset_instruction <= 1'b0;
      poweron_detect <= 1'b1;
      @(posedge aclk);
      while (internal_reset === 1'b1) begin
         @(posedge aclk);
         c++;
         guard(c);
      end
   endtask

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   initial begin
      {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
      {wstrb, clock_select_fuse, poweron_detect, brownout_detector} = '0;
      {testport_reset_instruction, comparator_bandgap_select} = '0;
      {converter_enable, failures, comparisons} = '0;
      {bready, rready, reset_pin_n, brownout_enable_fuse} = '1;
      void'($urandom(85478));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      pulse(3, cnt);
      flags = 1;
      chk_rd(reset_cause_status_offset, flags);
      chk_rd(watchdog_control_offset, 0);
      // stretch length follows the fuse: 64, 128, 256 cycles
      for (int k = 0; k < 3; k++) begin
         clock_select_fuse <= 4'(k);
         @(posedge aclk);
         pulse(k, cnt);
         len = delay_base_cycles << k;
         `CHK(cnt >= len && cnt <= len + 4, 1'b1)
         flags = flags | (1 << bits[k]);
         chk_rd(reset_cause_status_offset, flags);
      end
      clock_select_fuse <= 4'h0;
      brownout_enable_fuse <= 1'b0;
      brownout_detector <= 1'b1;
      repeat (4) @(posedge aclk);
      `CHK(internal_reset, 1'b0)
      brownout_detector <= 1'b0;
      brownout_enable_fuse <= 1'b1;
      axi_wr(reset_cause_status_offset, 32'h0000001F, 4'h0);
      chk_rd(reset_cause_status_offset, flags);
      // software clears with zeros, ones keep a flag
      repeat (4) begin
         d = $urandom;
         axi_wr(reset_cause_status_offset, d, 4'h1);
         flags = flags & d[4:0];
         chk_rd(reset_cause_status_offset, flags);
      end
      axi_wr(reset_cause_status_offset, 32'h0, 4'h1);
      pulse(0, cnt);
      pulse(3, cnt);
      chk_rd(reset_cause_status_offset, 1);
      axi_rd(4'hC);
      `CHK(resp, resp_slverr)
      `CHK(rd, 32'h0)
      axi_wr(4'hC, 32'h1, 4'h1);
      `CHK(resp, resp_slverr)
      axi_wr(watchdog_control_offset, 32'hFF, 4'h1);
      repeat (6) @(posedge aclk);
      chk_rd(watchdog_control_offset, 8'h0F);
      axi_wr(watchdog_control_offset, 32'h00, 4'h1);
      chk_rd(watchdog_control_offset, 8'h08);
      axi_wr(watchdog_control_offset, 32'h18, 4'h1);
      axi_wr(watchdog_control_offset, 32'h00, 4'h1);
      // let the turnoff window run out so bit 4 reads back clear
      repeat (6) @(posedge aclk);
      chk_rd(watchdog_control_offset, 8'h00);
      axi_wr(watchdog_control_offset, 32'h1D, 4'h1);
      repeat (6) @(posedge aclk);
      axi_wr(watchdog_control_offset, 32'h00, 4'h1);
      chk_rd(watchdog_control_offset, 8'h08);
      // timeout itself is far beyond the run length; restart only
      repeat (1000) @(posedge aclk);
      `CHK(i_dut.cur.wd_count > 8 && i_dut.cur.wd_count < 12, 1'b1)
      axi_wr(reset_control_offset, 32'h1, 4'h1);
      `CHK(resp, resp_okay)
      `CHK(i_dut.cur.wd_count, 0)
      pulse(0, cnt);
      chk_rd(watchdog_control_offset, 8'h00);
      for (int k = 0; k < 8; k++) begin
         {brownout_enable_fuse, comparator_bandgap_select,
            converter_enable} <= 3'(k);
         @(posedge aclk);
         @(posedge aclk);
         `CHK(bandgap_enable, |3'(k))
      end
      end_sim();
   end
endmodule
`default_nettype wire

/* rst_wdt_pkg.sv */
// constants for the reset and watchdog controller
package rst_wdt_pkg;
   localparam logic [3:0] reset_cause_status_offset = 4'h0;
   localparam logic [3:0] watchdog_control_offset = 4'h4;
   localparam logic [3:0] reset_control_offset = 4'h8;
   localparam int testport_flag_bit = 4;
   localparam int watchdog_flag_bit = 3;
   localparam int brownout_flag_bit = 2;
   localparam int pin_flag_bit = 1;
   localparam int poweron_flag_bit = 0;
   localparam int turnoff_enable_bit = 4;
   localparam int watchdog_enable_bit = 3;
   localparam int prescale_lsb = 0;
   localparam int restart_bit = 0;
   localparam logic [7:0] reset_cause_status_reset = 8'h00;
   localparam logic [7:0] watchdog_control_reset = 8'h00;
   localparam logic [2:0] turnoff_window_cycles = 3'h4;
   localparam int watchdog_base_log2 = 14;
   localparam int watchdog_counter_width = 22;
   localparam int delay_counter_width = 22;
   localparam int delay_base_cycles = 64;
   localparam int sys_clock_hz = 100000000;
   localparam int watchdog_osc_hz = 1000000;
   localparam logic [6:0] watchdog_osc_divide =
      7'(sys_clock_hz / (2 * watchdog_osc_hz));
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;
endpackage
